// *** tb/rtcc_core_assertions.sv ***
/*
  Checker for rtcc_core, bound to its ports.
  Assumes software shadows rebuilt from SFR writes match the core.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_core_assertions import rtcc_pkg::*; (
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          xtalClock,
  input wire rtcc_sfr_req_t sfrReq,
  input wire logic [7:0]    sfrReadAddr,
  input wire logic [7:0]    sfrRdata,
  input wire logic          clockIrq,
  input wire logic [3:0]    calPinEnable
);
  logic       keyArmed_q;  // Last write was the unlock key
  logic [7:0] ptr_q;       // Pointer shadow
  logic [7:0] aen_q;       // Alarm enable shadow
  logic [7:0] cfg_q;       // Config shadow; flags are not tracked
  wire  logic wData = sfrReq.write && sfrReq.addr == SFR_DATA;
  wire  logic wCfg  = sfrReq.write && sfrReq.addr == SFR_CONFIG;
  wire  logic [4:0] cfgSw   = {cfg_q[6:5], cfg_q[2:0]};
  wire  logic [7:0] ptrView = {ptr_q[7], 2'b00, ptr_q[4:0]};
  // Any write disarms the key
  always_ff @(posedge clock or posedge rst) begin
    if (rst) keyArmed_q <= 1'b0;
    else if (sfrReq.write) keyArmed_q <= sfrReq.addr == SFR_KEY && sfrReq.wdata == UNLOCK_KEY;
  end
  // Software-visible shadows
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_q <= 8'h00;
      aen_q <= 8'h00;
      cfg_q <= 8'h00;
    end else if (sfrReq.write) begin
      if (sfrReq.addr == SFR_POINTER) ptr_q <= sfrReq.wdata;
      if (sfrReq.addr == SFR_ALARM_EN) aen_q <= sfrReq.wdata;
      if (wCfg) cfg_q <= sfrReq.wdata;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_cal_cause; !$stable(calPinEnable) |-> $past(wData); endproperty
  a_cal_cause: assert property (p_cal_cause) else $error("pin enables moved without a data write");
  property p_cal_key; !$stable(calPinEnable) |-> $past(keyArmed_q); endproperty
  a_cal_key: assert property (p_cal_key) else $error("pin enables moved without the key");
  property p_cal_val;
    !$stable(calPinEnable) |-> calPinEnable == ($past(sfrReq.wdata[6]) ? $past(sfrReq.wdata[3:0]) : 4'h0);
  endproperty
  a_cal_val: assert property (p_cal_val) else $error("pin enables wrong value");
  property p_irq_en; clockIrq |-> cfg_q[5] || cfg_q[6]; endproperty
  a_irq_en: assert property (p_irq_en) else $error("interrupt with enables off");
  property p_irq_drop; $fell(clockIrq) |-> $past(wCfg); endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt dropped by itself");
  property p_cfg_top; $past(sfrReadAddr) == SFR_CONFIG |-> sfrRdata[7] == 1'b0; endproperty
  a_cfg_top: assert property (p_cfg_top) else $error("config bit 7 not zero");
  property p_cfg_sw;
    $past(sfrReadAddr) == SFR_CONFIG |-> {sfrRdata[6:5], sfrRdata[2:0]} == $past(cfgSw);
  endproperty
  a_cfg_sw: assert property (p_cfg_sw) else $error("config readback wrong");
  property p_ptr_rb; $past(sfrReadAddr) == SFR_POINTER |-> sfrRdata == $past(ptrView); endproperty
  a_ptr_rb: assert property (p_ptr_rb) else $error("pointer readback wrong");
  property p_aen_rb; $past(sfrReadAddr) == SFR_ALARM_EN |-> sfrRdata[4:0] == $past(aen_q[4:0]); endproperty
  a_aen_rb: assert property (p_aen_rb) else $error("alarm enable readback wrong");
  c_pins: cover property (calPinEnable == 4'ha);
  c_irq: cover property ($rose(clockIrq));
  c_ptr: cover property ($past(sfrReadAddr) == SFR_POINTER);
endmodule
bind rtcc_core rtcc_core_assertions rtcc_core_assertions_inst (.clock(clock), .rst(rst), .xtalClock(xtalClock),
  .sfrReq(sfrReq), .sfrReadAddr(sfrReadAddr), .sfrRdata(sfrRdata), .clockIrq(clockIrq), .calPinEnable(calPinEnable));
`default_nettype wire

// *** tb/rtcc_cpu.sv ***
/*
  Processor-core stand-in: SFR write and read tasks plus a gated crystal pin.
  Assumes the bench's 200 MHz clock; the pin stays low between bursts.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_cpu import rtcc_pkg::*; (
  input  wire logic          clock,
  output rtcc_sfr_req_t      sfrReq,
  output logic [7:0]         sfrReadAddr,
  input  wire logic [7:0]    sfrRdata,
  output logic               xtalClock
);
  // Idle bus and a still crystal pin at time zero
  initial begin
    sfrReq = '0;
    sfrReadAddr = SFR_DATA;
    xtalClock = 1'b0;
  end
  // One-cycle write; released fields show inverse, not stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 sfrReq = '{write: 1'b1, addr: a, wdata: d};
    @(posedge clock);
    #1 sfrReq = '{write: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Read an SFR; data lags the address by one edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1 sfrReadAddr = a;
    repeat (2) @(posedge clock);
    #1 d = sfrRdata;
  endtask
  // Protected write: pointer first, because any write spends the key
  task automatic pwr(input logic [4:0] i, input logic [7:0] d);
    wr(SFR_POINTER, {3'b100, i});
    wr(SFR_KEY, UNLOCK_KEY);
    wr(SFR_DATA, d);
  endtask
  // Read-direction pointer write copies the register into the data port
  task automatic rreg(input logic [4:0] i, output logic [7:0] d);
    wr(SFR_POINTER, {3'b000, i});
    rd(SFR_DATA, d);
  endtask
  // Crystal edges, sped up so a tick fits the run
  task automatic edges(input int n);
    repeat (n) begin
      @(posedge clock);
      #1 xtalClock = 1'b1;
      repeat (4) @(posedge clock);
      #1 xtalClock = 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (12) @(posedge clock);
  endtask
endmodule
`default_nettype wire

// *** tb/test_rtcc_core.sv ***
/*
  Self-checking bench for rtcc_core; one task per scenario.
  Assumes rtcc_cpu drives the SFR bus and the crystal pin.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rtcc_core import rtcc_pkg::*; ;
  logic          clock = 1'b0;  // 200 MHz
  logic          rst   = 1'b1;  // Held two cycles
  logic          xtalClock;
  rtcc_sfr_req_t sfrReq;
  logic [7:0]    sfrReadAddr;
  logic [7:0]    sfrRdata;
  logic          clockIrq;
  logic [3:0]    calPinEnable;
  int            errors = 0;
  int            check_count = 0;
  logic [7:0]    v;             // Last value read
  always #2.5 clock = ~clock;
  rtcc_core rtcc_core_inst (.clock(clock), .rst(rst), .xtalClock(xtalClock), .sfrReq(sfrReq),
    .sfrReadAddr(sfrReadAddr), .sfrRdata(sfrRdata), .clockIrq(clockIrq), .calPinEnable(calPinEnable));
  rtcc_cpu rtcc_cpu_inst (.clock(clock), .sfrReq(sfrReq), .sfrReadAddr(sfrReadAddr), .sfrRdata(sfrRdata),
    .xtalClock(xtalClock));
  // Case equality so an unknown never matches
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Reset values of the whole indexed set
  task automatic t_reset();
    for (int i = 1; i <= 16; i++) begin
      rtcc_cpu_inst.rreg(5'(i), v);
      chk("reset value", (i == 6 || i == 7) ? 8'h01 : 8'h00, v);
    end
    rtcc_cpu_inst.rd(SFR_POINTER, v);
    chk("pointer", 8'h10, v);
  endtask
  // Key missing, key spent, then unlocked writes
  task automatic t_key();
    rtcc_cpu_inst.wr(SFR_POINTER, 8'h81);
    rtcc_cpu_inst.wr(SFR_DATA, 8'h55);
    rtcc_cpu_inst.wr(SFR_KEY, UNLOCK_KEY);
    rtcc_cpu_inst.wr(SFR_POINTER, 8'h81);
    rtcc_cpu_inst.wr(SFR_DATA, 8'h66);
    rtcc_cpu_inst.rreg(IDX_FRACTION, v);
    chk("locked fraction", 8'h00, v);
    rtcc_cpu_inst.pwr(IDX_XTAL_OFS, 8'ha5);
    rtcc_cpu_inst.rreg(IDX_XTAL_OFS, v);
    chk("crystal offset", 8'ha5, v);
    rtcc_cpu_inst.pwr(IDX_CAL_CFG, 8'h4a);
    chk("pins on", 8'h0a, {4'h0, calPinEnable});
    rtcc_cpu_inst.pwr(IDX_CAL_CFG, 8'h0f);
    chk("pins off", 8'h00, {4'h0, calPinEnable});
    rtcc_cpu_inst.rreg(IDX_CAL_CFG, v);
    chk("cal config", 8'h0f, v);
  endtask
  // Load indices 1..8, low byte first; one tick
  task automatic t_tick(input logic [63:0] ld, input logic [63:0] ex);
    for (int i = 0; i < 8; i++) rtcc_cpu_inst.pwr(5'(i + 1), ld[8*i +: 8]);
    rtcc_cpu_inst.edges(256);
    for (int i = 0; i < 8; i++) begin
      rtcc_cpu_inst.rreg(5'(i + 1), v);
      chk("calendar", ex[8*i +: 8], v);
    end
  endtask
  // Target 2: no hit after one tick, hit after two
  task automatic t_interval();
    rtcc_cpu_inst.pwr(IDX_INTERVAL, 8'h02);
    rtcc_cpu_inst.wr(SFR_CONFIG, 8'h24);
    for (int k = 0; k < 2; k++) begin
      rtcc_cpu_inst.edges(256);
      rtcc_cpu_inst.rd(SFR_CONFIG, v);
      chk("interval flag", k ? 8'h2c : 8'h24, v);
    end
    chk("interval irq", 8'h01, {7'h0, clockIrq});
    rtcc_cpu_inst.wr(SFR_CONFIG, 8'h00);
    chk("irq cleared", 8'h00, {7'h0, clockIrq});
  endtask
  // Second and date enabled: mismatch, then match
  task automatic t_alarm();
    rtcc_cpu_inst.pwr(IDX_ALARM_S_MATCH, 8'h05);
    rtcc_cpu_inst.pwr(IDX_ALARM_DATE_MATCH, 8'h1e);
    rtcc_cpu_inst.wr(SFR_ALARM_EN, 8'h11);
    rtcc_cpu_inst.wr(SFR_CONFIG, 8'h40);
    for (int k = 0; k < 2; k++) begin
      rtcc_cpu_inst.pwr(IDX_FRACTION, 8'h7f);
      rtcc_cpu_inst.pwr(IDX_SECOND, 8'h04);
      rtcc_cpu_inst.edges(256);
      rtcc_cpu_inst.rd(SFR_CONFIG, v);
      chk("alarm flag", k ? 8'h50 : 8'h40, v);
      rtcc_cpu_inst.pwr(IDX_ALARM_DATE_MATCH, 8'h1d);
    end
    chk("alarm irq", 8'h01, {7'h0, clockIrq});
    rtcc_cpu_inst.rd(SFR_ALARM_EN, v);
    chk("alarm enables", 8'h11, {3'h0, v[4:0]});
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    t_reset();
    t_key();
    t_tick(64'h01_02_1c_06_17_3b_3b_7f, 64'h01_03_01_00_00_00_00_00);
    t_tick(64'hff_0c_1f_03_17_3b_3b_7f, 64'h00_01_01_04_00_00_00_00);
    t_tick(64'h04_02_1c_00_17_3b_3b_7f, 64'h04_02_1d_01_00_00_00_00);
    rtcc_cpu_inst.rd(SFR_CONFIG, v);
    chk("no alarm", 8'h00, v);
    t_interval();
    t_alarm();
    end_of_test();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clock);
    errors++;
    end_of_test();
  end
endmodule
`default_nettype wire

// *** verilog/rtcc_core.sv ***
/*
  Calendar clock core: timebase prescaler, calendar counter cascade,
  interval timer, alarm comparators and the indirect register port.
  Assumes xtalClock is the calibrated 32.768 kHz clock arriving on a pin,
  far slower than the 200 MHz system clock, and that SFR writes come as
  single-cycle strobes from the processor core.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_core import rtcc_pkg::*; (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          xtalClock,
  input  wire rtcc_sfr_req_t sfrReq,
  input  wire logic [7:0]    sfrReadAddr,
  output logic      [7:0]    sfrRdata,
  output logic               clockIrq,
  output logic      [3:0]    calPinEnable
);

  // Pin synchroniser, three stages
  logic       xtalSync1_q;      // First stage, read only by stage two
  logic       xtalSync2_q;      // Second stage
  logic       xtalSync3_q;      // Third stage
  logic       xtalLevel_q;      // Accepted pin level
  logic       xtalRise;         // One accepted rising edge
  logic [7:0] prescale_q;       // Edges within one fraction tick
  logic       fracStep;         // 1/128 second pulse

  // Register port state
  logic [7:0] pointer_q;        // clock_reg_pointer
  logic [7:0] dataPort_q;       // clock_reg_data_port
  logic       keyArmed_q;       // Unlock key just written
  logic [7:0] config_q;         // clock_config_reg
  logic [4:0] alarmEnable_q;    // Alarm field enables
  logic [7:0] sfrRdata_q;       // Registered read data

  // Plain storage registers of the set
  logic [7:0] intervalTarget_q; // interval_target
  logic [7:0] alarmSec_q;       // alarm_s_match
  logic [7:0] alarmMin_q;       // alarm_m_match
  logic [7:0] alarmHour_q;      // alarm_hour_match
  logic [7:0] alarmWday_q;      // alarm_weekday_match
  logic [7:0] alarmDate_q;      // alarm_date_match
  logic [7:0] calConfig_q;      // calib_output_config
  logic [7:0] xtalOffset_q;     // crystal_temp_offset

  // Interval timer and alarm
  logic [7:0] intervalCount_q;  // Interval counter
  logic       intervalTick;     // Selected timebase pulse
  logic       intervalHit;      // Count reached target
  logic       alarmEval_q;      // Seconds just updated
  logic       alarmHit;         // All enabled fields match

  // Counter values and carries
  logic [7:0] fracCount, secCount, minCount, hourCount;
  logic [7:0] wdayCount, dateCount, monthCount, yearCount;
  logic       fracWrap, secWrap, minWrap, hourWrap;
  logic       dateWrap, monthWrap;
  logic [7:0] monthLength;      // Last day of current month

  // Decoded register-port write
  logic       dataWrite;        // Write to the data SFR
  logic       regWrite;         // Indirect write performed
  logic [4:0] regIndex;         // Selected pointer index
  logic       protectedIdx;     // Index needs the key
  logic [7:0] loadStrobes;      // Counter loads, fraction..year

  // Value of the clock register at an index; reserved and unused read zero
  function automatic logic [7:0] regValue(input logic [4:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      IDX_FRACTION: v = fracCount;
      IDX_SECOND:   v = secCount;
      IDX_MINUTE:   v = minCount;
      IDX_HOUR:     v = hourCount;
      IDX_WEEKDAY:  v = wdayCount;
      IDX_DATE:     v = dateCount;
      IDX_MONTH:    v = monthCount;
      IDX_YEAR:     v = yearCount;
      IDX_INTERVAL: v = intervalTarget_q;
      IDX_ALARM_S_MATCH:   v = alarmSec_q;
      IDX_ALARM_M_MATCH:   v = alarmMin_q;
      IDX_ALARM_HOUR_MATCH:  v = alarmHour_q;
      IDX_AL_WDAY:  v = alarmWday_q;
      IDX_ALARM_DATE_MATCH:  v = alarmDate_q;
      IDX_CAL_CFG:  v = calConfig_q;
      IDX_XTAL_OFS: v = xtalOffset_q;
      default:      v = 8'h00;
    endcase
    return v;
  endfunction

  // Crystal pin synchroniser: stage one feeds stage two only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xtalSync1_q <= 1'b0;
      xtalSync2_q <= 1'b0;
      xtalSync3_q <= 1'b0;
    end else begin
      xtalSync1_q <= xtalClock;
      xtalSync2_q <= xtalSync1_q;
      xtalSync3_q <= xtalSync2_q;
    end
  end

  // A rising level change counts once stages two and three agree
  assign xtalRise = xtalSync2_q && xtalSync3_q && !xtalLevel_q;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xtalLevel_q <= 1'b0;
    end else if (xtalSync2_q == xtalSync3_q) begin
      xtalLevel_q <= xtalSync3_q;
    end
  end

  // 256 crystal edges make one 1/128 second tick
  assign fracStep = xtalRise && (prescale_q == 8'(EDGES_PER_FRAC - 1));

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prescale_q <= 8'h00;
    end else if (xtalRise) begin
      prescale_q <= prescale_q + 8'h01;  // Wraps naturally at 256
    end
  end

  // Leap years: year register counts from a year divisible by four
  always_comb begin
    case (monthCount)
      8'h02:   monthLength = (yearCount[1:0] == 2'b00) ? 8'h1d : 8'h1c;
      8'h04,
      8'h06,
      8'h09,
      8'h0b:   monthLength = 8'h1e;
      default: monthLength = 8'h1f;
    endcase
  end

  // Counter cascade; each stage steps on the carry of the one below, except date, which steps on the hour carry like weekday
  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) fracCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(FRAC_MAX),
    .step(fracStep), .load(loadStrobes[0]), .loadValue(sfrReq.wdata),
    .count(fracCount), .wrap(fracWrap));

  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) secCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(SEC_MAX),
    .step(fracWrap), .load(loadStrobes[1]), .loadValue(sfrReq.wdata),
    .count(secCount), .wrap(secWrap));

  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) minCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(MIN_MAX),
    .step(secWrap), .load(loadStrobes[2]), .loadValue(sfrReq.wdata),
    .count(minCount), .wrap(minWrap));

  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) hourCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(HOUR_MAX),
    .step(minWrap), .load(loadStrobes[3]), .loadValue(sfrReq.wdata),
    .count(hourCount), .wrap(hourWrap));

  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) wdayCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(WDAY_MAX),
    .step(hourWrap), .load(loadStrobes[4]), .loadValue(sfrReq.wdata),
    .count(wdayCount), .wrap());

  rtcc_wrap_counter #(.RESET_VALUE(RST_DATE)) dateCounter (
    .clock(clock), .rst(rst), .minValue(8'h01), .maxValue(monthLength),
    .step(hourWrap), .load(loadStrobes[5]), .loadValue(sfrReq.wdata),
    .count(dateCount), .wrap(dateWrap));

  rtcc_wrap_counter #(.RESET_VALUE(RST_MONTH)) monthCounter (
    .clock(clock), .rst(rst), .minValue(8'h01), .maxValue(MONTH_MAX),
    .step(dateWrap), .load(loadStrobes[6]), .loadValue(sfrReq.wdata),
    .count(monthCount), .wrap(monthWrap));

  // Year wraps 255 to 0 as a plain 8-bit count
  rtcc_wrap_counter #(.RESET_VALUE(RST_ZERO)) yearCounter (
    .clock(clock), .rst(rst), .minValue(8'h00), .maxValue(YEAR_MAX),
    .step(monthWrap), .load(loadStrobes[7]), .loadValue(sfrReq.wdata),
    .count(yearCount), .wrap());

  // Indirect write decode; the data SFR write itself is the trigger
  assign dataWrite    = sfrReq.write && (sfrReq.addr == SFR_DATA);
  assign regIndex     = pointer_q[PTR_IDX_MSB:0];
  // Timekeeping and crystal registers are locked behind the key
  assign protectedIdx = ((regIndex >= IDX_FRACTION) && (regIndex <= IDX_YEAR)) ||
                        (regIndex == IDX_CAL_CFG) || (regIndex == IDX_XTAL_OFS);
  assign regWrite     = dataWrite && pointer_q[PTR_DIR_BIT] &&
                        (!protectedIdx || keyArmed_q);

  // One load strobe per counter, index one upward
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      loadStrobes[i] = regWrite && (regIndex == 5'(i + 1));
    end
  end

  // Key lives for exactly the next SFR write; any write disarms it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      keyArmed_q <= 1'b0;
    end else if (sfrReq.write) begin
      keyArmed_q <= (sfrReq.addr == SFR_KEY) && (sfrReq.wdata == UNLOCK_KEY);
    end
  end

  // Pointer and data port; a read-direction pointer write fetches a copy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pointer_q  <= 8'h00;
      dataPort_q <= 8'h00;
    end else if (sfrReq.write && sfrReq.addr == SFR_POINTER) begin
      pointer_q <= sfrReq.wdata & 8'h9f;  // Bits 6:5 read as zero
      if (!sfrReq.wdata[PTR_DIR_BIT]) begin
        dataPort_q <= regValue(sfrReq.wdata[PTR_IDX_MSB:0]);
      end
    end else if (dataWrite) begin
      dataPort_q <= sfrReq.wdata;
    end
  end

  // Plain storage registers; no key needed for interval and alarm values
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intervalTarget_q <= RST_ZERO;
      alarmSec_q       <= RST_ZERO;
      alarmMin_q       <= RST_ZERO;
      alarmHour_q      <= RST_ZERO;
      alarmWday_q      <= RST_ZERO;
      alarmDate_q      <= RST_ZERO;
      calConfig_q      <= RST_ZERO;
      xtalOffset_q     <= RST_ZERO;
    end else if (regWrite) begin
      case (regIndex)
        IDX_INTERVAL: intervalTarget_q <= sfrReq.wdata;
        IDX_ALARM_S_MATCH:   alarmSec_q       <= sfrReq.wdata;
        IDX_ALARM_M_MATCH:   alarmMin_q       <= sfrReq.wdata;
        IDX_ALARM_HOUR_MATCH:  alarmHour_q      <= sfrReq.wdata;
        IDX_AL_WDAY:  alarmWday_q      <= sfrReq.wdata;
        IDX_ALARM_DATE_MATCH:  alarmDate_q      <= sfrReq.wdata;
        IDX_CAL_CFG:  calConfig_q      <= sfrReq.wdata;
        IDX_XTAL_OFS: xtalOffset_q     <= sfrReq.wdata;
        default:      ;                                 // Counters or reserved
      endcase
    end
  end

  // Alarm field enables
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarmEnable_q <= 5'h00;
    end else if (sfrReq.write && sfrReq.addr == SFR_ALARM_EN) begin
      alarmEnable_q <= sfrReq.wdata[4:0];
    end
  end

  // Interval timebase: fraction tick, second, minute or hour
  always_comb begin
    case (config_q[CFG_ITS_LSB +: 2])
      2'b00:   intervalTick = fracStep;
      2'b01:   intervalTick = fracWrap;
      2'b10:   intervalTick = secWrap;
      2'b11:   intervalTick = minWrap;
      default: intervalTick = 1'b0;
    endcase
  end

  // Hit when the count after this tick reaches the target
  assign intervalHit = config_q[CFG_IT_EN] && intervalTick &&
                       ((intervalCount_q + 8'h01) == intervalTarget_q);

  // Eight-bit interval counter, cleared on a hit or while stopped
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      intervalCount_q <= 8'h00;
    end else if (!config_q[CFG_IT_EN] || intervalHit) begin
      intervalCount_q <= 8'h00;
    end else if (intervalTick) begin
      intervalCount_q <= intervalCount_q + 8'h01;
    end
  end

  // Compare one cycle after the seconds stage moved, on settled values
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alarmEval_q <= 1'b0;
    end else begin
      alarmEval_q <= fracWrap;
    end
  end

  // A disabled field always passes; at least one must be enabled
  assign alarmHit = alarmEval_q && (|alarmEnable_q) &&
                    (!alarmEnable_q[AEN_SEC]  || secCount  == alarmSec_q)  &&
                    (!alarmEnable_q[AEN_MIN]  || minCount  == alarmMin_q)  &&
                    (!alarmEnable_q[AEN_HOUR] || hourCount == alarmHour_q) &&
                    (!alarmEnable_q[AEN_WDAY] || wdayCount == alarmWday_q) &&
                    (!alarmEnable_q[AEN_DATE] || dateCount == alarmDate_q);

  // Config SFR; flags clear by writing zero, but a same-cycle set wins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      config_q <= 8'h00;
    end else begin
      if (sfrReq.write && sfrReq.addr == SFR_CONFIG) begin
        config_q <= sfrReq.wdata & 8'h7f;
      end
      if (intervalHit) begin
        config_q[CFG_IT_FLAG] <= 1'b1;
      end
      if (alarmHit) begin
        config_q[CFG_AL_FLAG] <= 1'b1;
      end
    end
  end

  // Registered read data for the addressed SFR
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sfrRdata_q <= 8'h00;
    end else begin
      case (sfrReadAddr)
        SFR_CONFIG:   sfrRdata_q <= config_q;
        SFR_ALARM_EN: sfrRdata_q <= {3'h0, alarmEnable_q};
        SFR_POINTER:  sfrRdata_q <= pointer_q;
        SFR_DATA:     sfrRdata_q <= dataPort_q;
        default:      sfrRdata_q <= 8'h00;  // Key reads back zero
      endcase
    end
  end

  assign sfrRdata = sfrRdata_q;

  // Pending interrupt: a flag with its enable
  assign clockIrq = (config_q[CFG_IT_FLAG] && config_q[CFG_IT_IE]) ||
                    (config_q[CFG_AL_FLAG] && config_q[CFG_AL_IE]);

  // Pin selects only count while the calibration output is enabled
  assign calPinEnable = calConfig_q[CAL_EN_BIT] ? calConfig_q[3:0] : 4'h0;

endmodule
`default_nettype wire

// *** verilog/rtcc_pkg.sv ***
/*
  Package for the calendar clock core: SFR addresses, pointer indices,
  field positions, reset values and the request carrier.
  Assumes a single 200 MHz system clock and an 8-bit SFR bus from the core.
*/
// Operation
// - Fraction counter: 1/128 s, wraps 127, steps seconds
// - Seconds wrap 59 to 0, step minutes
// - Minutes wrap 59 to 0, step hours
// - Hours wrap 23, step weekday and date
// - Weekday steps daily, wraps 6 to 0
// - Date wraps to 1 after month end
// - Month runs 1..12, wrap steps year
// - Year is 8-bit, steps once per year
// - Interval counter is eight bits wide
// - Second/minute/hour alarms compared only when enabled
// - Weekday/date alarms compared only when enabled
// - All enabled fields match: alarm flag, interrupt
// - Eight-bit crystal temperature offset register
// - Reset: date, month one; others zero
// - Index 0x0F calibration config; 0x00 reserved
// - Pointer selects; direction bit picks read/write
// - Protected writes need key 0xEA just before
// - February has 29 days in leap years
package rtcc_pkg;

  // SFR addresses seen by the processor core
  localparam logic [7:0] SFR_CONFIG   = 8'ha1;  // clock_config_reg
  localparam logic [7:0] SFR_ALARM_EN = 8'ha2;  // Alarm field enables
  localparam logic [7:0] SFR_POINTER  = 8'ha3;  // clock_reg_pointer
  localparam logic [7:0] SFR_DATA     = 8'ha4;  // clock_reg_data_port
  localparam logic [7:0] SFR_KEY      = 8'hc1;  // write_unlock_key

  // Key value that unlocks protected clock registers
  localparam logic [7:0] UNLOCK_KEY = 8'hea;

  // Pointer indices of the clock register set
  localparam logic [4:0] IDX_RESERVED  = 5'h00;
  localparam logic [4:0] IDX_FRACTION  = 5'h01;
  localparam logic [4:0] IDX_SECOND    = 5'h02;
  localparam logic [4:0] IDX_MINUTE    = 5'h03;
  localparam logic [4:0] IDX_HOUR      = 5'h04;
  localparam logic [4:0] IDX_WEEKDAY   = 5'h05;
  localparam logic [4:0] IDX_DATE      = 5'h06;
  localparam logic [4:0] IDX_MONTH     = 5'h07;
  localparam logic [4:0] IDX_YEAR      = 5'h08;
  localparam logic [4:0] IDX_INTERVAL  = 5'h09;
  localparam logic [4:0] IDX_ALARM_S_MATCH    = 5'h0a;
  localparam logic [4:0] IDX_ALARM_M_MATCH    = 5'h0b;
  localparam logic [4:0] IDX_ALARM_HOUR_MATCH   = 5'h0c;
  localparam logic [4:0] IDX_AL_WDAY   = 5'h0d;
  localparam logic [4:0] IDX_ALARM_DATE_MATCH   = 5'h0e;
  localparam logic [4:0] IDX_CAL_CFG   = 5'h0f;
  localparam logic [4:0] IDX_XTAL_OFS  = 5'h10;

  // Pointer SFR fields
  localparam int PTR_DIR_BIT = 7;  // pointer_direction_bit
  localparam int PTR_IDX_MSB = 4;

  // Config SFR fields
  localparam int CFG_ITS_LSB  = 0;  // interval_timebase_select [1:0]
  localparam int CFG_IT_EN    = 2;  // Interval timer run
  localparam int CFG_IT_FLAG  = 3;  // interval_match_flag
  localparam int CFG_AL_FLAG  = 4;  // alarm_match_flag
  localparam int CFG_IT_IE    = 5;  // Interval interrupt enable
  localparam int CFG_AL_IE    = 6;  // Alarm interrupt enable

  // Alarm enable SFR field positions
  localparam int AEN_SEC  = 0;  // alarm_s_field_enable
  localparam int AEN_MIN  = 1;  // alarm_m_field_enable
  localparam int AEN_HOUR = 2;  // alarm_h_field_enable
  localparam int AEN_WDAY = 3;  // alarm_weekday_field_enable
  localparam int AEN_DATE = 4;  // alarm_dom_field_enable

  // Calibration config fields
  localparam int CAL_EN_BIT = 6;

  // Timebase
  localparam int XTAL_HZ        = 32768;
  localparam int FRAC_PER_SEC   = 128;
  localparam int EDGES_PER_FRAC = XTAL_HZ / FRAC_PER_SEC;

  // Counter limits
  localparam logic [7:0] FRAC_MAX  = 8'h7f;
  localparam logic [7:0] SEC_MAX   = 8'h3b;
  localparam logic [7:0] MIN_MAX   = 8'h3b;
  localparam logic [7:0] HOUR_MAX  = 8'h17;
  localparam logic [7:0] WDAY_MAX  = 8'h06;
  localparam logic [7:0] MONTH_MAX = 8'h0c;
  localparam logic [7:0] YEAR_MAX  = 8'hff;

  // Reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_DATE  = 8'h01;
  localparam logic [7:0] RST_MONTH = 8'h01;

  // One SFR write as issued by the core
  typedef struct packed {
    logic       write;  // One-cycle write strobe
    logic [7:0] addr;   // SFR address
    logic [7:0] wdata;  // Write data
  } rtcc_sfr_req_t;

endpackage

// *** verilog/rtcc_wrap_counter.sv ***
/*
  One calendar counter stage: steps, wraps from a limit back to a floor,
  and can be loaded by software.
  Assumes step and load are one-cycle pulses in the system clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module rtcc_wrap_counter import rtcc_pkg::*; #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic [7:0] minValue,
  input  wire logic [7:0] maxValue,
  input  wire logic       step,
  input  wire logic       load,
  input  wire logic [7:0] loadValue,
  output logic      [7:0] count,
  output logic            wrap
);

  logic [7:0] count_q;  // Current value

  // Wrap on the limit or above, so an out-of-range load recovers
  assign wrap  = step && !load && (count_q >= maxValue);
  assign count = count_q;

  // Software load beats a step arriving in the same cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_q <= RESET_VALUE;
    end else if (load) begin
      count_q <= loadValue;
    end else if (wrap) begin
      count_q <= minValue;
    end else if (step) begin
      count_q <= count_q + 8'h01;
    end
  end

endmodule
`default_nettype wire
